// ---- hdl/adc_conv_pkg.sv ----
package adc_conv_pkg;

    // Core clock rate and converter timing
    localparam int unsigned CORE_CLK_PERIOD_NS = 20;
    localparam int unsigned ANALOG_CONV_TIME_NS = 9000;
    localparam int unsigned TEMP_CONV_TIME_NS = 27000;
    localparam int unsigned TIMER_W = 11;

    // Busy is a least time, so round up to whole core cycles
    localparam int unsigned ANALOG_CONV_CYCLES =
        (ANALOG_CONV_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int unsigned TEMP_CONV_CYCLES =
        (TEMP_CONV_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

    // Result word layout
    localparam int unsigned RESULT_WIDTH = 10;
    localparam logic [3:0] RESULT_MSB_POS = 4'h9;
    localparam logic [3:0] READ_LAST_FALL = 4'ha;
    localparam logic [3:0] READ_FALL_SAT = 4'hb;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // Control byte layout and reset value
    localparam int unsigned CTRL_WIDTH = 8;
    localparam logic [3:0] CTRL_BITS = 4'h8;
    localparam logic [3:0] CTRL_LAST_BIT = 4'h7;
    localparam int unsigned CHANNEL_POS = 5;
    localparam logic [2:0] TEMP_CHANNEL = 3'h0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Control byte: channel select in the top three bits
    typedef struct packed {
        logic [2:0] channel;
        logic [4:0] spare;
    } ctrl_byte_t;

    // Result published toward the serial port
    typedef struct packed {
        logic valid;
        logic [9:0] code;
    } result_word_t;

    // Converter states, Gray coded along track, convert, power down
    typedef enum logic [1:0] {
        ST_TRACK = 2'h0,
        ST_CONVERT = 2'h1,
        ST_POWER_DOWN = 2'h3
    } conv_state_t;

endpackage

// ---- hdl/bit_sync2.sv ----
`timescale 1ns/1ps
module bit_sync2
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    // Clock and reset of the receiving domain
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Level from another domain or a pin
    input wire logic async_in,
    // Synchronised level
    output logic sync_out
);

    // First stage, read only by the second stage
    logic meta;

    // Two flops in series give metastability time to settle
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ---- hdl/adc_conv_serial_port.sv ----
// Contract
// - Convert-start level at end picks mode
// - Start held low: power down as busy falls
// - Power back up on convert-start rising edge
// - Slave five-wire port on host serial clock
// - Select low writes, select high reads
// - Chip select high: port stays silent
// - MSB at select rise, shift later falls
// - Ten bits MSB first, eight allowed
// - Output floats on select fall or deselect
// - Reading erases the result
// - First eight rising edges load control byte
// - Falling start begins conversion, busy timed
// - Channel zero is temperature, selected at reset
`timescale 1ns/1ps
module adc_conv_serial_port
import adc_conv_pkg::*;
#(
    parameter logic [TIMER_W-1:0] ANALOG_CYCLES = TIMER_W'(ANALOG_CONV_CYCLES),
    parameter logic [TIMER_W-1:0] TEMP_CYCLES = TIMER_W'(TEMP_CONV_CYCLES)
)
(
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Host serial clock, the link domain
    input wire logic sclk_in,
    // Conversion start pin
    input wire logic convert_start_n_in,
    // Serial port pins
    input wire logic cs_n_in,
    input wire logic rd_wr_in,
    input wire logic din_in,
    output logic dout_out,
    output logic dout_oe_out,
    // Code delivered by the successive approximation array
    input wire logic [RESULT_WIDTH-1:0] conv_code_in,
    // Converter status toward the pins and the analog side
    output logic busy_out,
    output logic hold_out,
    output logic powered_down_out,
    output logic [2:0] channel_out,
    output logic [CTRL_WIDTH-1:0] control_byte_out,
    output logic result_valid_out
);

    // Reset release synchroniser
    logic rst_meta;
    logic rst_n;

    // The reset is asserted at once and released on the core clock
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin levels and the control toggle after two flops in the core domain
    logic convert_start_n_s;
    logic cs_n_s;
    logic rd_wr_s;
    logic ctrl_toggle_s;
    // Toggle flipped by the link side per finished control byte
    logic ctrl_toggle;
    // Control byte held stable in the link domain
    ctrl_byte_t ctrl_hold;

    bit_sync2 #(.RESET_VALUE(1'b1)) u_sync_convert_start_n
    (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .async_in(convert_start_n_in),
        .sync_out(convert_start_n_s)
    );

    bit_sync2 #(.RESET_VALUE(1'b1)) u_sync_cs
    (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .async_in(cs_n_in),
        .sync_out(cs_n_s)
    );

    bit_sync2 #(.RESET_VALUE(1'b0)) u_sync_rd_wr
    (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .async_in(rd_wr_in),
        .sync_out(rd_wr_s)
    );

    bit_sync2 #(.RESET_VALUE(1'b0)) u_sync_ctrl
    (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .async_in(ctrl_toggle),
        .sync_out(ctrl_toggle_s)
    );

    // Previous synchronised levels for edge detection
    logic convert_start_n_prev;
    logic read_prev;
    logic ctrl_toggle_prev;
    // Open read frame as the core sees it, declared ahead of its first reader
    wire logic read_active_s = rd_wr_s & ~cs_n_s;

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            convert_start_n_prev <= 1'b1;
            read_prev <= 1'b0;
            ctrl_toggle_prev <= 1'b0;
        end
        else
        begin
            convert_start_n_prev <= convert_start_n_s;
            read_prev <= read_active_s;
            ctrl_toggle_prev <= ctrl_toggle_s;
        end
    end

    // Decoded events in the core domain
    wire logic convert_start_n_fall = convert_start_n_prev & ~convert_start_n_s;
    wire logic convert_start_n_rise = ~convert_start_n_prev & convert_start_n_s;
    wire logic read_end = read_prev & ~read_active_s;
    wire logic ctrl_strobe = ctrl_toggle_s ^ ctrl_toggle_prev;

    // Converter state and timer
    conv_state_t state;
    conv_state_t next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    // Control byte as seen by the converter
    ctrl_byte_t ctrl_reg;

    wire logic conv_end = (state == ST_CONVERT) && (timer == '0);
    // Temperature takes the long conversion time
    wire logic [TIMER_W-1:0] conv_length =
        (ctrl_reg.channel == TEMP_CHANNEL) ? TEMP_CYCLES : ANALOG_CYCLES;
    wire logic [TIMER_W-1:0] timer_dec = timer - TIMER_W'(1);

    // Next state of the converter
    always_comb
    begin
        next_state = state;
        next_timer = timer;
        case (state)
            ST_TRACK:
            begin
                // Falling start puts the sampler in hold and starts the clock
                if (convert_start_n_fall)
                begin
                    next_state = ST_CONVERT;
                    next_timer = conv_length - TIMER_W'(1);
                end
            end
            ST_CONVERT:
            begin
                if (conv_end)
                begin
                    // Start still low at the end selects the power-down mode
                    if (convert_start_n_s)
                    begin
                        next_state = ST_TRACK;
                    end
                    else
                    begin
                        next_state = ST_POWER_DOWN;
                    end
                end
                else
                begin
                    next_timer = timer_dec;
                end
            end
            ST_POWER_DOWN:
            begin
                // Only a rising start wakes the converter again
                if (convert_start_n_rise)
                begin
                    next_state = ST_TRACK;
                end
            end
            default:
            begin
                next_state = ST_TRACK;
                next_timer = '0;
            end
        endcase
    end

    // Converter state register
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_TRACK;
            timer <= '0;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // Control byte taken over when the toggle is seen; the held byte is stable by then
    // The timer is loaded at start, so a later write cannot stretch a running conversion
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= ctrl_byte_t'(CTRL_RESET);
        end
        else if (ctrl_strobe)
        begin
            ctrl_reg <= ctrl_hold;
        end
    end

    // Result store and validity
    logic [RESULT_WIDTH-1:0] result_reg;
    logic result_valid;
    result_word_t out_word;

    // A new result beats an erase in the same cycle
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_reg <= RESULT_RESET;
            result_valid <= 1'b0;
        end
        else if (conv_end)
        begin
            result_reg <= conv_code_in;
            result_valid <= 1'b1;
        end
        else if (read_end)
        begin
            result_valid <= 1'b0;
        end
    end

    // Published word frozen while a read is open, so the link sees stable bits
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_word <= '0;
        end
        else if (!read_active_s)
        begin
            out_word <= {result_valid, result_reg};
        end
    end

    // Frame resets built from the pins; a closed frame holds its counter at zero
    wire logic read_frame_n = rst_n & rd_wr_in & ~cs_n_in;
    wire logic write_frame_n = rst_n & ~rd_wr_in & ~cs_n_in;

    // Falling serial clock edges seen in the read frame
    logic [3:0] fall_cnt;

    // Restarts only when a new read frame opens
    always_ff @(negedge sclk_in or negedge read_frame_n)
    begin
        if (!read_frame_n)
        begin
            fall_cnt <= 4'h0;
        end
        else if (fall_cnt != READ_FALL_SAT)
        begin
            fall_cnt <= 4'(fall_cnt + 4'h1);
        end
    end

    // First fall keeps the MSB, each later fall moves one bit down
    wire logic [3:0] bit_pos = (fall_cnt == 4'h0) ? RESULT_MSB_POS : 4'(READ_LAST_FALL - fall_cnt);
    wire logic bit_in_range = (fall_cnt <= READ_LAST_FALL);
    // An erased result reads as zeros
    wire logic read_bit = bit_in_range & out_word.valid & out_word.code[bit_pos];

    // Output pin; the enable drops on the first of deselect or select fall
    assign dout_out = read_bit;
    assign dout_oe_out = read_frame_n;

    // Write frame bit counter and shift register
    logic [3:0] wr_cnt;
    logic [CTRL_WIDTH-2:0] wr_shift;

    // Counts the rising edges of one write frame and stops at eight
    always_ff @(posedge sclk_in or negedge write_frame_n)
    begin
        if (!write_frame_n)
        begin
            wr_cnt <= 4'h0;
            wr_shift <= '0;
        end
        else if (wr_cnt != CTRL_BITS)
        begin
            wr_cnt <= 4'(wr_cnt + 4'h1);
            wr_shift <= {wr_shift[CTRL_WIDTH-3:0], din_in};
        end
    end

    // Eighth rising edge completes the byte; later edges do nothing
    always_ff @(posedge sclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_hold <= ctrl_byte_t'(CTRL_RESET);
            ctrl_toggle <= 1'b0;
        end
        else if (write_frame_n && wr_cnt == CTRL_LAST_BIT)
        begin
            ctrl_hold <= {wr_shift, din_in};
            ctrl_toggle <= ~ctrl_toggle;
        end
    end

    // Status outputs; busy, hold and power-down decoded from the state register
    assign busy_out = (state == ST_CONVERT);
    assign hold_out = (state == ST_CONVERT);
    assign powered_down_out = (state == ST_POWER_DOWN);
    assign channel_out = ctrl_reg.channel;
    assign control_byte_out = ctrl_reg;
    assign result_valid_out = result_valid;

endmodule

// ---- dv/adc_conv_serial_port_checker.sv ----
`timescale 1ns/1ps
module adc_conv_serial_port_checker
import adc_conv_pkg::*;
#(
    parameter logic [TIMER_W-1:0] ANALOG_CYCLES = 11'h00a,
    parameter logic [TIMER_W-1:0] TEMP_CYCLES = 11'h01e
)
(
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Host pins
    input wire logic convert_start_n_in,
    input wire logic cs_n_in,
    input wire logic rd_wr_in,
    // Device outputs
    input wire logic dout_oe_out,
    input wire logic busy_out,
    input wire logic hold_out,
    input wire logic powered_down_out,
    input wire logic [2:0] channel_out,
    input wire logic [CTRL_WIDTH-1:0] control_byte_out,
    input wire logic result_valid_out
);
    // Cycles busy has stood high so far
    logic [TIMER_W-1:0] busy_len;
    logic [TIMER_W-1:0] next_busy_len;
    assign next_busy_len = busy_out ? busy_len + 11'h001 : 11'h000;

    // Busy length counter
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            busy_len <= 11'h000;
        else
            busy_len <= next_busy_len;
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    // End of a conversion, and end of an open read frame
    sequence s_conv_end;
        $fell(busy_out);
    endsequence
    sequence s_read_end;
        $fell(rd_wr_in) && $past(dout_oe_out);
    endsequence

    a_oe_from_pins: assert property ($past(rstn_in, 3) |-> dout_oe_out == (rd_wr_in && !cs_n_in))
        else $error("output enable does not follow the pins");
    a_hold_is_busy: assert property (hold_out == busy_out)
        else $error("hold differs from busy");
    a_busy_length: assert property (s_conv_end |->
        busy_len == ((channel_out == TEMP_CHANNEL) ? TEMP_CYCLES : ANALOG_CYCLES))
        else $error("busy length wrong");
    a_busy_cause: assert property ($rose(busy_out) |-> !$past(convert_start_n_in, 3))
        else $error("busy rose without a start");
    a_valid_at_end: assert property (s_conv_end |-> result_valid_out)
        else $error("result not valid at end");
    // The mode is judged on the synchronised pin, three core edges behind the pin itself
    a_pd_by_level: assert property (s_conv_end |-> powered_down_out == !$past(convert_start_n_in, 3))
        else $error("power-down does not match start level");
    a_pd_wakeup: assert property (powered_down_out && convert_start_n_in |-> ##[1:4] !powered_down_out)
        else $error("no wake-up after start rise");
    a_pd_idle: assert property (powered_down_out |-> !busy_out)
        else $error("busy while powered down");
    a_read_erases: assert property (s_read_end |-> ##[1:4] !result_valid_out)
        else $error("read did not erase result");
    a_chan_field: assert property (channel_out == control_byte_out[7:5])
        else $error("channel not the top control bits");
endmodule

bind adc_conv_serial_port adc_conv_serial_port_checker #(.ANALOG_CYCLES(ANALOG_CYCLES), .TEMP_CYCLES(TEMP_CYCLES))
    checker_i (.core_clk_in, .rstn_in, .convert_start_n_in, .cs_n_in, .rd_wr_in, .dout_oe_out, .busy_out,
    .hold_out, .powered_down_out, .channel_out, .control_byte_out, .result_valid_out);

// ---- dv/adc_host_model.sv ----
`timescale 1ns/1ps
module adc_host_model
(
    // Data from the device
    input wire logic dout_in,
    // Pins toward the device
    output logic sclk_out,
    output logic cs_n_out,
    output logic rd_wr_out,
    output logic din_out,
    output logic convert_start_n_out
);
    realtime last_read_end; // For the quiet time before a conversion

    // Idle pins; serial clock parks high outside frames
    initial
    begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        rd_wr_out = 1'b0;
        din_out = 1'b0;
        convert_start_n_out = 1'b1;
        last_read_end = 0.0;
    end

    // One serial clock: data moves on the fall, is sampled on the rise
    task automatic tick(output logic seen);
        sclk_out = 1'b0;
        #40;
        sclk_out = 1'b1;
        seen = dout_in;
        #40;
    endtask

    // Read nbits MSB first; sel low leaves chip select high
    task automatic read_word(input int nbits, input logic sel, output logic [9:0] w);
        logic b;
        w = 10'h000;
        #7;
        cs_n_out = !sel;
        #20;
        rd_wr_out = 1'b1;
        #40;
        for (int i = 0; i < nbits; i++)
        begin
            tick(b);
            w[9-i] = b;
        end
        rd_wr_out = 1'b0;
        #20;
        cs_n_out = 1'b1;
        last_read_end = $realtime;
    endtask

    // Write a control byte; clocks past eight carry junk
    task automatic write_byte(input logic [7:0] val, input int nclk);
        logic b;
        #7;
        rd_wr_out = 1'b1;
        #20;
        rd_wr_out = 1'b0;
        #20;
        cs_n_out = 1'b0;
        for (int i = 0; i < nclk; i++)
        begin
            din_out = (i < 8) ? val[7-i] : !din_out;
            tick(b);
        end
        #20;
        cs_n_out = 1'b1;
        din_out = !din_out; // Released line shows no stale value
    endtask

    // Start a conversion in mode one or mode two
    task automatic convert(input logic mode2);
        if ($realtime < last_read_end + 100.0)
            #(last_read_end + 100.0 - $realtime);
        #7;
        convert_start_n_out = 1'b0;
        if (mode2)
            #2000;
        else
            #100;
        convert_start_n_out = 1'b1;
    endtask
endmodule

// ---- dv/adc_conv_serial_port_tb.sv ----
`timescale 1ns/1ps
module adc_conv_serial_port_tb
import adc_conv_pkg::*;
;
    logic core_clk_in, rstn_in, sclk_in, convert_start_n_in, cs_n_in, rd_wr_in, din_in;
    logic dout_out, dout_oe_out, busy_out, hold_out, powered_down_out, result_valid_out;
    logic [RESULT_WIDTH-1:0] conv_code_in;
    logic [2:0] channel_out;
    logic [CTRL_WIDTH-1:0] control_byte_out;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [9:0] word;
    logic oe_seen;
    // One row: control byte, code, mode, expected channel and read word
    typedef struct packed {
        logic [7:0] ctrl;
        logic [9:0] code;
        logic mode2;
        logic [2:0] exp_ch;
        logic [9:0] exp_word;
    } row_t;
    row_t rows [4] = '{'{8'h20, 10'h2a5, 1'b0, 3'h1, 10'h2a5}, '{8'he0, 10'h15a, 1'b1, 3'h7, 10'h15a},
        '{8'h00, 10'h200, 1'b0, 3'h0, 10'h200}, '{8'h1f, 10'h3ff, 1'b1, 3'h0, 10'h3ff}};

    // Short conversion counts keep the run brief
    adc_conv_serial_port #(.ANALOG_CYCLES(11'h00a), .TEMP_CYCLES(11'h01e)) adc_conv_serial_port_i (.core_clk_in,
        .rstn_in, .sclk_in, .convert_start_n_in, .cs_n_in, .rd_wr_in, .din_in, .dout_out, .dout_oe_out,
        .conv_code_in, .busy_out, .hold_out, .powered_down_out, .channel_out, .control_byte_out, .result_valid_out);
    // A released output shows the inverse, so a read off a floating line cannot pass by chance
    adc_host_model adc_host_model_i (.dout_in(dout_oe_out ? dout_out : ~dout_out), .sclk_out(sclk_in), .cs_n_out(cs_n_in),
        .rd_wr_out(rd_wr_in), .din_out(din_in), .convert_start_n_out(convert_start_n_in));

    // Core clock, 20 ns
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    // Hang guard
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_in);
        #2;
    endtask

    // Run one conversion and look at the outputs as busy drops
    task automatic convert(input logic mode2);
        int n;
        n = 0;
        fork
            adc_host_model_i.convert(mode2);
            begin
                while (busy_out !== 1'b1 && n < 300)
                begin
                    @(posedge core_clk_in);
                    n++;
                end
                while (busy_out !== 1'b0 && n < 300)
                begin
                    @(posedge core_clk_in);
                    n++;
                end
                #2;
                check(16'(n < 300), 16'h1);
                check(16'(result_valid_out), 16'h1);
                check(16'(powered_down_out), 16'(mode2));
            end
        join
        // The rising start needs two synchroniser edges and one more to leave power-down
        settle(4);
        check(16'(powered_down_out), 16'h0);
    endtask

    initial
    begin
        rstn_in = 1'b0;
        conv_code_in = 10'h000;
        repeat (16) @(posedge core_clk_in);
        #2 rstn_in = 1'b1;
        settle(6);
        check({busy_out, hold_out, powered_down_out, result_valid_out, dout_oe_out, channel_out, control_byte_out},
            16'h0000);
        $display("reset test done");
        foreach (rows[i])
        begin
            adc_host_model_i.write_byte(rows[i].ctrl, 8);
            settle(8);
            check(16'(control_byte_out), 16'(rows[i].ctrl));
            check(16'(channel_out), 16'(rows[i].exp_ch));
            conv_code_in = rows[i].code;
            convert(rows[i].mode2);
            adc_host_model_i.read_word(10, 1'b1, word);
            settle(6);
            check(16'(word), 16'(rows[i].exp_word));
            check(16'(result_valid_out), 16'h0);
            $display("row %0d done", i);
        end
        // Erased result reads as zeros on a fresh frame
        adc_host_model_i.read_word(10, 1'b1, word);
        settle(2);
        check(16'(word), 16'h0000);
        $display("erase test done");
        // Clocks beyond the eighth are ignored
        adc_host_model_i.write_byte(8'ha3, 12);
        settle(8);
        check(16'(control_byte_out), 16'h00a3);
        $display("long write test done");
        // Deselected read stays silent and keeps the result
        conv_code_in = 10'h1c6;
        convert(1'b0);
        oe_seen = 1'b0;
        fork
            adc_host_model_i.read_word(10, 1'b0, word);
            repeat (60) @(posedge core_clk_in) oe_seen |= dout_oe_out;
        join
        settle(2);
        check(16'(oe_seen), 16'h0);
        check(16'(result_valid_out), 16'h1);
        // Eight-clock read returns the upper bits
        adc_host_model_i.read_word(8, 1'b1, word);
        settle(6);
        check(16'(word), 16'h01c4);
        check(16'(result_valid_out), 16'h0);
        $display("short read test done");
        finish_test();
    end
endmodule
